//--- logic/octal_host_port.sv
// host bus port, address decode, channel registers, fifos and pin routing
// Function
// - low four address bits pick channel register
// - address bits four to six pick channel
// - top address bit selects global registers
// - bidirectional data bus, device drives reads
// - style high: separate read strobe, chip select
// - read strobe fall reads, drives byte out
// - write stored at write strobe trailing edge
// - style low: write pin is direction line
// - style low: chip select is the strobe
// - one open-drain low interrupt for all channels
// - global register shows all channel pending bits
// - receive idles high, optional infrared inversion
// - transmit carries normal or infrared data
// - request/ready outputs: flow or direction control
// - clear/set-ready inputs throttle transmit when enabled
// - carrier and ring readable, active low
// - per channel 64-byte transmit, receive fifos
// - broadcast write reaches all channels at once
`timescale 1ns/10ps
module octal_host_port
	import octal_port_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [7:0]               addrIn,
	input  wire logic [7:0]               dataIn,
	output logic      [7:0]               dataOut_q,
	output logic                          dataOe_n_q,
	input  wire logic                     read_strobe_n,
	input  wire logic                     write_strobe_n,
	input  wire logic                     chipSel_n,
	input  wire logic                     strobeStyle,
	input  wire logic                     intIn,
	output logic                          intOut_q,
	output logic                          intOe_n_q,
	input  wire chanPins_s [NUM_CH-1:0]   chanPinsIn,
	input  wire logic [NUM_CH-1:0]        txSerial,
	input  wire logic [NUM_CH-1:0]        txIrPulse,
	input  wire logic [NUM_CH-1:0]        txActive,
	input  wire logic [NUM_CH-1:0]        txPull,
	output logic      [NUM_CH-1:0][7:0]   txByte_q,
	output logic      [NUM_CH-1:0]        txValid_q,
	input  wire logic [NUM_CH-1:0]        rxPush,
	input  wire logic [NUM_CH-1:0][7:0]   rxByte,
	output logic      [NUM_CH-1:0]        rxDecoded_q,
	output logic      [NUM_CH-1:0]        serialOut_q,
	output logic      [NUM_CH-1:0]        reqSendOut_n_q,
	output logic      [NUM_CH-1:0]        termReadyOut_n_q
);

	// true when an access at address a reaches channel ch
	function automatic logic chanHit(input logic [7:0] a, input int ch, input logic bc);
		chanHit = ~a[ADDR_GLOBAL] & (bc | (a[ADDR_CH_MSB:ADDR_CH_LSB] == 3'(ch)));
	endfunction

	pinIn_s     pinRaw;
	pinIn_s     pinS1_q;
	pinIn_s     pinS2_q;
	pinIn_s     pinS3_q;
	pinIn_s     pinF_q;
	pinIn_s     pinF_d;
	busState_e  state_q;
	busState_e  state_d;
	logic [7:0] wrAddr_q;
	logic [7:0] wrData_q;
	logic       bcast_q;
	logic [NUM_CH-1:0]      pend;
	logic [NUM_CH-1:0][7:0] chanRd;

	// every pin passes four flops, three stages and a filter; a bit moves once stages two and three agree
	assign pinRaw = {addrIn, dataIn, read_strobe_n, write_strobe_n, chipSel_n,
		strobeStyle, intIn, chanPinsIn};
	assign pinF_d = (pinS2_q & pinS3_q) | (pinF_q & (pinS2_q ^ pinS3_q));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinS1_q <= '1;
			pinS2_q <= '1;
			pinS3_q <= '1;
			pinF_q  <= '1;
		end else begin
			pinS1_q <= pinRaw;
			pinS2_q <= pinS1_q;
			pinS3_q <= pinS2_q;
			pinF_q  <= pinF_d;
		end
	end

	// access decode; in direction style the read strobe is ignored since it is tied high
	wire styleSep = pinF_q.strobeStyle;
	wire csAct    = ~pinF_q.chipSel_n;
	wire rdSep    = ~pinF_q.readStrobe_n & csAct;
	wire wrSep    = ~pinF_q.writeStrobe_n & csAct;
	wire rdDir    = csAct & pinF_q.writeStrobe_n;
	wire wrDir    = csAct & ~pinF_q.writeStrobe_n;
	wire rdAct    = styleSep ? rdSep : rdDir;
	wire wrAct    = styleSep ? wrSep : wrDir;

	wire       startRead = (state_q == BUS_IDLE) & rdAct;
	wire       wrCommit  = (state_q == BUS_WRITE) & ~wrAct;
	wire [3:0] rdIdx     = pinF_q.addr[ADDR_IDX_MSB:ADDR_IDX_LSB];
	wire [2:0] rdCh      = pinF_q.addr[ADDR_CH_MSB:ADDR_CH_LSB];
	wire       rdGlobal  = pinF_q.addr[ADDR_GLOBAL];
	wire [3:0] wrIdx     = wrAddr_q[ADDR_IDX_MSB:ADDR_IDX_LSB];
	wire       wrGlobal  = wrAddr_q[ADDR_GLOBAL];

	// global read map: pending summary, broadcast control, sensed interrupt line
	wire [7:0] globalRd = (rdIdx == GIDX_INT_SRC) ? pend :
		(rdIdx == GIDX_BCAST) ? {7'h00, bcast_q} :
		(rdIdx == GIDX_LINE) ? {7'h00, pinF_q.intLine} : REG_RESET;
	wire [7:0] readByte = rdGlobal ? globalRd : chanRd[rdCh];

	// bus sequencer: one access per strobe, write committed at its trailing edge
	always_comb begin
		state_d = state_q;
		case (state_q)
			BUS_IDLE: begin
				if (rdAct) begin
					state_d = BUS_READ;
				end else if (wrAct) begin
					state_d = BUS_WRITE;
				end
			end
			BUS_READ: begin
				if (!rdAct) begin
					state_d = BUS_IDLE;
				end
			end
			BUS_WRITE: begin
				if (!wrAct) begin
					state_d = BUS_IDLE;
				end
			end
			default: state_d = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= BUS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// write latch trails the filtered pins by a cycle so the trailing edge sees held data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrAddr_q <= REG_RESET;
			wrData_q <= REG_RESET;
		end else if (state_q == BUS_WRITE && wrAct) begin
			wrAddr_q <= pinF_q.addr;
			wrData_q <= pinF_q.data;
		end
	end

	// data bus drive: enable low while a read is held
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dataOut_q  <= REG_RESET;
			dataOe_n_q <= 1'h1;
		end else if (startRead) begin
			dataOut_q  <= readByte;
			dataOe_n_q <= 1'h0;
		end else if (state_q != BUS_READ || !rdAct) begin
			dataOe_n_q <= 1'h1;
		end
	end

	// broadcast enable makes channel writes land in every channel
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bcast_q <= 1'h0;
		end else if (wrCommit && wrGlobal && wrIdx == GIDX_BCAST) begin
			bcast_q <= wrData_q[BCAST_BIT];
		end
	end

	// open drain interrupt: pull low while any channel is pending
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			intOut_q  <= 1'h0;
			intOe_n_q <= 1'h1;
		end else begin
			intOut_q  <= 1'h0;
			intOe_n_q <= ~|pend;
		end
	end

	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			logic [7:0]       regs_q [REGS_PER_CH];
			logic [7:0]       txMem_q [FIFO_DEPTH];
			logic [7:0]       rxMem_q [FIFO_DEPTH];
			logic [PTR_W-1:0] txWr_q;
			logic [PTR_W-1:0] txRd_q;
			logic [PTR_W-1:0] rxWr_q;
			logic [PTR_W-1:0] rxRd_q;

			chanPins_s  pins;
			assign pins = pinF_q.chan[c];
			wire [7:0] intEn    = regs_q[IDX_INT_EN];
			wire [7:0] modemCtl = regs_q[IDX_MODEM_CTL];
			wire [7:0] featCtl  = regs_q[IDX_FEAT_CTL];
			wire [7:0] enhFeat  = regs_q[IDX_ENH_FEAT];

			// fifo occupancy from wrapping pointers one bit wider than the index
			wire [PTR_W-1:0] txCount = txWr_q - txRd_q;
			wire [PTR_W-1:0] rxCount = rxWr_q - rxRd_q;
			wire txEmpty = (txCount == '0);
			wire rxEmpty = (rxCount == '0);
			wire txFull  = (txCount == FIFO_FULL);
			wire rxFull  = (rxCount == FIFO_FULL);

			wire hit     = wrCommit & chanHit(wrAddr_q, c, bcast_q);
			wire txPush  = hit & (wrIdx == IDX_DATA) & ~txFull;
			wire regWr   = hit & (wrIdx != IDX_DATA) & (wrIdx != IDX_MODEM_STAT);
			wire rxPop   = startRead & chanHit(pinF_q.addr, c, 1'h0) & (rdIdx == IDX_DATA)
				& ~rxEmpty;
			// either handshake input deasserted stalls the transmit pull
			wire flowOk  = ~enhFeat[ENH_AUTO_IN] | (~pins.clearSend_n & ~pins.setReady_n);
			wire txTake  = txPull[c] & ~txEmpty & flowOk;
			wire rxTake  = rxPush[c] & ~rxFull;

			// modem status reads pins live as active-high bits
			wire [7:0] modemStat = {~pins.carrier_n, ~pins.ring_n, ~pins.setReady_n,
				~pins.clearSend_n, 4'h0};
			assign chanRd[c] = (rdIdx == IDX_DATA) ? rxMem_q[rxRd_q[PTR_W-2:0]] :
				(rdIdx == IDX_MODEM_STAT) ? modemStat : regs_q[rdIdx];
			assign pend[c] = (intEn[INTEN_RX_BIT] & ~rxEmpty) | (intEn[INTEN_TX_BIT] & txEmpty);

			// register file
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					regs_q <= '{default: REG_RESET};
				end else if (regWr) begin
					regs_q[wrIdx] <= wrData_q;
				end
			end

			// fifo storage carries no reset; only pointers define content
			always_ff @(posedge clk) begin
				if (txPush) begin
					txMem_q[txWr_q[PTR_W-2:0]] <= wrData_q;
				end
				if (rxTake) begin
					rxMem_q[rxWr_q[PTR_W-2:0]] <= rxByte[c];
				end
			end

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					txWr_q <= '0;
					txRd_q <= '0;
					rxWr_q <= '0;
					rxRd_q <= '0;
				end else begin
					txWr_q <= txPush ? txWr_q + PTR_ONE : txWr_q;
					txRd_q <= txTake ? txRd_q + PTR_ONE : txRd_q;
					rxWr_q <= rxTake ? rxWr_q + PTR_ONE : rxWr_q;
					rxRd_q <= rxPop ? rxRd_q + PTR_ONE : rxRd_q;
				end
			end

			// one byte handed to the serial engine per accepted pull
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					txByte_q[c]  <= REG_RESET;
					txValid_q[c] <= 1'h0;
				end else begin
					txValid_q[c] <= txTake;
					if (txTake) begin
						txByte_q[c] <= txMem_q[txRd_q[PTR_W-2:0]];
					end
				end
			end

			// line side: infrared or plain data, flow or direction control outputs
			wire rxStop = (rxCount >= RX_STOP_LEVEL);
			wire rtsD   = featCtl[FEAT_DIRCTL] ? ~txActive[c] :
				enhFeat[ENH_AUTO_OUT] ? rxStop : ~modemCtl[MCTL_RTS_BIT];
			wire dtrD   = featCtl[FEAT_DIRCTL] ? ~txActive[c] :
				enhFeat[ENH_AUTO_OUT] ? rxStop : ~modemCtl[MCTL_DTR_BIT];

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					rxDecoded_q[c]      <= 1'h1;
					serialOut_q[c]      <= 1'h1;
					reqSendOut_n_q[c]   <= 1'h1;
					termReadyOut_n_q[c] <= 1'h1;
				end else begin
					rxDecoded_q[c]      <= featCtl[FEAT_IRMODE] ?
						(pins.rx ^ featCtl[FEAT_IRINV]) : pins.rx;
					serialOut_q[c]      <= featCtl[FEAT_IRMODE] ? txIrPulse[c] : txSerial[c];
					reqSendOut_n_q[c]   <= rtsD;
					termReadyOut_n_q[c] <= dtrD;
				end
			end
		end
	endgenerate

endmodule // octal_host_port

//--- pkg/octal_port_pkg.sv
// shared constants and types for the octal serial host port
package octal_port_pkg;
	localparam int NUM_CH        = 8;
	localparam int REGS_PER_CH   = 16;
	localparam int FIFO_DEPTH    = 64;
	localparam int PTR_W         = 7;

	// address fields
	localparam int ADDR_IDX_LSB  = 0;
	localparam int ADDR_IDX_MSB  = 3;
	localparam int ADDR_CH_LSB   = 4;
	localparam int ADDR_CH_MSB   = 6;
	localparam int ADDR_GLOBAL   = 7;

	// per-channel register indices
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_INT_EN     = 4'h1;
	localparam logic [3:0] IDX_MODEM_CTL  = 4'h4;
	localparam logic [3:0] IDX_MODEM_STAT = 4'h6;
	localparam logic [3:0] IDX_FEAT_CTL   = 4'h8;
	localparam logic [3:0] IDX_ENH_FEAT   = 4'h9;

	// global register indices
	localparam logic [3:0] GIDX_INT_SRC = 4'h0;
	localparam logic [3:0] GIDX_BCAST   = 4'h1;
	localparam logic [3:0] GIDX_LINE    = 4'h2;

	// field positions
	localparam int INTEN_RX_BIT  = 0;
	localparam int INTEN_TX_BIT  = 1;
	localparam int MCTL_DTR_BIT  = 0;
	localparam int MCTL_RTS_BIT  = 1;
	localparam int FEAT_IRINV    = 4;
	localparam int FEAT_DIRCTL   = 5;
	localparam int FEAT_IRMODE   = 6;
	localparam int ENH_AUTO_OUT  = 6;
	localparam int ENH_AUTO_IN   = 7;
	localparam int MSTAT_CTS_BIT = 4;
	localparam int MSTAT_DSR_BIT = 5;
	localparam int MSTAT_RI_BIT  = 6;
	localparam int MSTAT_CD_BIT  = 7;
	localparam int BCAST_BIT     = 0;

	localparam logic [7:0]       REG_RESET     = 8'h00;
	localparam logic [PTR_W-1:0] FIFO_FULL     = 7'h40;
	localparam logic [PTR_W-1:0] RX_STOP_LEVEL = 7'h38;
	localparam logic [PTR_W-1:0] PTR_ONE       = 7'h01;

	typedef struct packed {
		logic rx;
		logic clearSend_n;
		logic setReady_n;
		logic carrier_n;
		logic ring_n;
	} chanPins_s;

	typedef struct packed {
		logic [7:0]                 addr;
		logic [7:0]                 data;
		logic                       readStrobe_n;
		logic                       writeStrobe_n;
		logic                       chipSel_n;
		logic                       strobeStyle;
		logic                       intLine;
		chanPins_s [NUM_CH-1:0]     chan;
	} pinIn_s;

	typedef enum {BUS_IDLE, BUS_READ, BUS_WRITE} busState_e;
endpackage

//--- sim/host_model.sv
// host processor model on the parallel bus, either bus style
`timescale 1ns/10ps
module host_model (
	input  wire logic       clk,
	input  wire logic       style,
	input  wire logic [7:0] busIn,
	output logic      [7:0] addr,
	output logic      [7:0] busOut,
	output logic            rdStrobe_n,
	output logic            wrStrobe_n,
	output logic            chipSel_n
);
	// idle bus, all strobes high
	initial begin
		addr = 8'h00;
		busOut = 8'hA5;
		rdStrobe_n = 1'h1;
		wrStrobe_n = 1'h1;
		chipSel_n = 1'h1;
	end
	// strobe held past the filter, address kept after release, data kept for six cycles after release
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk);
		addr = a;
		busOut = d;
		wrStrobe_n = ~wr;
		rdStrobe_n = ~(style & ~wr);
		chipSel_n = 1'h0;
		repeat (8) @(posedge clk);
		q = busIn;
		@(negedge clk);
		rdStrobe_n = 1'h1;
		wrStrobe_n = 1'h1;
		chipSel_n = 1'h1;
		repeat (6) @(negedge clk);
		busOut = ~d; // released data must not look held
	endtask
endmodule // host_model

//--- sim/octal_port_chk.sv
// checker on the host port pins and line outputs
`timescale 1ns/10ps
module octal_port_chk
	import octal_port_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              read_strobe_n,
	input wire logic              write_strobe_n,
	input wire logic              chipSel_n,
	input wire logic              strobeStyle,
	input wire logic [7:0]        dataOut_q,
	input wire logic              dataOe_n_q,
	input wire logic              intOut_q,
	input wire logic [NUM_CH-1:0] txPull,
	input wire logic [NUM_CH-1:0] txValid_q,
	input wire logic [NUM_CH-1:0] txSerial,
	input wire logic [NUM_CH-1:0] txIrPulse,
	input wire logic [NUM_CH-1:0] serialOut_q
);
	logic readPin;
	logic writePin;
	// raw pin requests; the design only sees them after its filter
	assign readPin = strobeStyle ? ~read_strobe_n & ~chipSel_n : ~chipSel_n & write_strobe_n;
	assign writePin = ~chipSel_n & ~write_strobe_n;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_readIdle;
		!readPin [*8];
	endsequence
	sequence s_writeHeld;
		writePin [*8];
	endsequence
	a_int_open_drain: assert property (intOut_q == 1'h0)
		else $error("interrupt pin value not low");
	a_oe_from_read: assert property ($fell(dataOe_n_q) |-> $past(readPin, 3) && $past(readPin, 4))
		else $error("data driven without a read");
	a_oe_release: assert property (s_readIdle |-> dataOe_n_q)
		else $error("data bus still driven");
	a_write_undriven: assert property (s_writeHeld |-> dataOe_n_q)
		else $error("data bus driven during write");
	a_read_data_held: assert property (!dataOe_n_q && !$past(dataOe_n_q) |-> $stable(dataOut_q))
		else $error("read data changed while driven");
	a_one_per_strobe: assert property ($rose(dataOe_n_q) |-> !$past(readPin, 3))
		else $error("data released while read held");
	a_tx_needs_pull: assert property ((txValid_q & ~$past(txPull)) == 8'h00)
		else $error("transmit byte without pull");
	a_serial_source: assert property ($past(rst_n) |->
		((serialOut_q ^ $past(txSerial)) & (serialOut_q ^ $past(txIrPulse))) == 8'h00)
		else $error("transmit pin from no source");
endmodule // octal_port_chk

//--- sim/testbench.sv
// self-checking bench for the octal host port
`timescale 1ns/10ps
module testbench;
	import octal_port_pkg::*;
	logic clk, rst_n, strobeStyle, dataOe_n_q, intOut_q, intOe_n_q, intIn;
	logic read_strobe_n, write_strobe_n, chipSel_n;
	logic [2:0] c;
	logic [7:0] addrIn, busOut, dataIn, dataOut_q, q, d;
	logic [NUM_CH-1:0] txSerial, txIrPulse, txActive, txPull, txValid_q, rxPush;
	logic [NUM_CH-1:0] rxDecoded_q, serialOut_q, reqSendOut_n_q, termReadyOut_n_q;
	logic [NUM_CH-1:0][7:0] txByte_q, rxByte;
	chanPins_s [NUM_CH-1:0] chanPinsIn;
	int n_errors = 0;
	int cmp_count = 0;
	int seed;
	// wire levels: device wins the data bus when enabled, pull-up on interrupt
	assign dataIn = dataOe_n_q ? busOut : dataOut_q;
	assign intIn = intOe_n_q ? 1'h1 : intOut_q;
	host_model host (.clk(clk), .style(strobeStyle), .busIn(dataIn), .addr(addrIn),
		.busOut(busOut), .rdStrobe_n(read_strobe_n), .wrStrobe_n(write_strobe_n),
		.chipSel_n(chipSel_n));
	octal_host_port uut (.clk(clk), .rst_n(rst_n), .addrIn(addrIn), .dataIn(dataIn),
		.dataOut_q(dataOut_q), .dataOe_n_q(dataOe_n_q), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .chipSel_n(chipSel_n), .strobeStyle(strobeStyle),
		.intIn(intIn), .intOut_q(intOut_q), .intOe_n_q(intOe_n_q), .chanPinsIn(chanPinsIn),
		.txSerial(txSerial), .txIrPulse(txIrPulse), .txActive(txActive), .txPull(txPull),
		.txByte_q(txByte_q), .txValid_q(txValid_q), .rxPush(rxPush), .rxByte(rxByte),
		.rxDecoded_q(rxDecoded_q), .serialOut_q(serialOut_q),
		.reqSendOut_n_q(reqSendOut_n_q), .termReadyOut_n_q(termReadyOut_n_q));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// serial engine bits change at random every cycle, idle during reset
	always @(negedge clk)
		{txSerial, txIrPulse} <= rst_n ? 16'($random(seed)) : 16'hFF00;
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host.access(1'h1, a, v, q);
	endtask
	task automatic rd(input logic [7:0] a);
		host.access(1'h0, a, 8'h00, q);
	endtask
	// bounded wait for the shared interrupt wire
	task automatic waitInt(input logic lvl);
		for (int i = 0; i < 20 && intIn !== lvl; i++)
			@(negedge clk);
		check("intIn", {7'h00, intIn}, {7'h00, lvl});
		if (intIn !== lvl) end_of_test();
	endtask
	task automatic pull(input int ch);
		@(negedge clk);
		txPull[ch] = 1'h1;
		@(negedge clk);
		txPull[ch] = 1'h0;
	endtask
	function automatic logic [7:0] adr(input logic [2:0] ch, input logic [3:0] idx);
		return {1'h0, ch, idx};
	endfunction
	function automatic logic [7:0] statusOf(input chanPins_s p);
		return {~p.carrier_n, ~p.ring_n, ~p.setReady_n, ~p.clearSend_n, 4'h0};
	endfunction
	initial begin
		seed = 32'h7668;
		rst_n = 1'h0;
		strobeStyle = 1'h1;
		{txActive, txPull, rxPush} = 24'h000000;
		rxByte = '0;
		chanPinsIn = '1;
		repeat (5) @(negedge clk);
		rst_n = 1'h1;
		check("oe", {7'h00, dataOe_n_q}, 8'h01);
		// neighbouring channels keep apart, both styles, top indices
		for (int i = 0; i < 12; i++) begin
			strobeStyle = (i < 6);
			c = 3'($random(seed));
			d = 8'($random(seed));
			wr(adr(c, 4'(10 + i % 6)), d);
			wr(adr(3'(c + 1), 4'(10 + i % 6)), ~d);
			rd(adr(c, 4'(10 + i % 6)));
			check("reg", q, d);
			rd(adr(3'(c + 1), 4'(10 + i % 6)));
			check("nextCh", q, ~d);
		end
		strobeStyle = 1'h1;
		wr(8'h81, 8'h01);
		rd(8'hF1);
		check("global", q, 8'h01);
		d = 8'($random(seed));
		wr(adr(3'h2, 4'hB), d);
		rd(adr(3'h7, 4'hB));
		check("bcast", q, d);
		wr(8'h81, 8'h00);
		rd(8'h82);
		check("intLine", q, 8'h01);
		for (int i = 0; i < 4; i++) begin
			chanPinsIn[i] = 5'($random(seed));
			rd(adr(3'(i), IDX_MODEM_STAT));
			check("status", q, statusOf(chanPinsIn[i]));
		end
		chanPinsIn = '1;
		@(negedge clk);
		rxByte[4] = d;
		rxPush[4] = 1'h1;
		@(negedge clk);
		rxPush[4] = 1'h0;
		rd(adr(3'h4, IDX_DATA));
		check("rxFifo", q, d);
		// tx-empty interrupt, throttled pull, then the byte comes out
		wr(adr(3'h5, IDX_INT_EN), 8'h02);
		waitInt(1'h0);
		rd(8'h80);
		check("source", q, 8'h20);
		d = 8'($random(seed));
		wr(adr(3'h5, IDX_DATA), d);
		waitInt(1'h1);
		wr(adr(3'h5, IDX_ENH_FEAT), 8'h80);
		chanPinsIn[5].clearSend_n = 1'h0;
		repeat (6) @(negedge clk);
		pull(5);
		check("held", txValid_q, 8'h00);
		chanPinsIn[5].setReady_n = 1'h0;
		repeat (6) @(negedge clk);
		pull(5);
		check("valid", txValid_q, 8'h20);
		check("byte", txByte_q[5], d);
		wr(adr(3'h6, IDX_MODEM_CTL), 8'h02);
		repeat (3) @(negedge clk);
		check("rts", reqSendOut_n_q, 8'hBF);
		wr(adr(3'h6, IDX_FEAT_CTL), 8'h70);
		txActive[6] = 1'h1;
		chanPinsIn[6].rx = 1'h0;
		repeat (6) @(negedge clk);
		check("dir", termReadyOut_n_q, 8'hBF);
		check("irRx", rxDecoded_q, 8'hFF);
		// automatic request output: empty receive fifo asks the peer to send
		wr(adr(3'h7, IDX_ENH_FEAT), 8'h40);
		repeat (3) @(negedge clk);
		check("autoRts", reqSendOut_n_q, 8'h3F);
		end_of_test();
	end
endmodule // testbench
bind octal_host_port octal_port_chk chk (.clk(clk), .rst_n(rst_n),
	.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .chipSel_n(chipSel_n),
	.strobeStyle(strobeStyle), .dataOut_q(dataOut_q), .dataOe_n_q(dataOe_n_q),
	.intOut_q(intOut_q), .txPull(txPull), .txValid_q(txValid_q), .txSerial(txSerial),
	.txIrPulse(txIrPulse), .serialOut_q(serialOut_q));
